// ==== logic/async_serial_transceiver.sv ====
// Asynchronous serial transceiver with an AHB-Lite register slave.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module async_serial_transceiver
    import uart_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output var  logic [31:0] HRDATA,
    output var  logic        HREADYOUT,
    output var  logic        HRESP,
    input  wire logic        SERIAL_IN_PIN,
    output var  logic        SERIAL_OUT_PIN,
    input  wire logic        CLEAR_TO_SEND_N,
    output var  logic        REQUEST_TO_SEND_N,
    output var  logic        TX_IRQ,
    output var  logic        RX_IRQ,
    output var  logic        ERR_IRQ
);
    localparam int         AW       = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE  = (AW + 1)'(1);
    localparam logic [AW:0] CNT_LVL3 = (AW + 1)'(RX_LEVEL_THREE);

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("DEPTH must be a power of two of at least four");
    end

    typedef struct packed {
        logic                      hreadyout;
        logic                      hresp;
        logic [31:0]               hrdata;
        logic                      wr_pending;
        logic [7:0]                wr_addr;
        logic [3:0]                wr_lanes;
        logic [15:0]               mode;
        logic [15:0]               baud_div;
        logic [15:0]               baud_cnt;
        logic [1:0]                tx_sel;
        logic [1:0]                rx_sel;
        logic                      tx_en;
        logic                      brk;
        logic                      overrun_error_flag;
        logic [DEPTH-1:0][8:0]     txq;
        logic [AW-1:0]             tx_rd;
        logic [AW-1:0]             tx_wr;
        logic [AW:0]               tx_cnt;
        logic [DEPTH-1:0][10:0]    rxq;
        logic [AW-1:0]             rx_rd;
        logic [AW-1:0]             rx_wr;
        logic [AW:0]               rx_cnt;
        tx_state_type              tx_state;
        logic [FRAME_W-1:0]        tx_shift;
        logic [3:0]                tx_bits;
        logic [3:0]                tx_phase;
        logic                      tx_is_break;
        rx_state_type              rx_state;
        logic [3:0]                rx_phase;
        logic [3:0]                rx_idx;
        logic [11:0]               rx_shift;
        logic                      serial_out;
        logic                      rts_n;
        logic                      tx_irq;
        logic                      rx_irq;
        logic                      err_irq;
    } state_type;

    state_type s;
    state_type n;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [3:0] byte_lanes(input logic [2:0] size, input logic [1:0] low);
        logic [3:0] m;
        m = 4'hF;
        if (size == HSIZE_BYTE) begin
            m = 4'h1 << low;
        end else if (size == HSIZE_HALF) begin
            m = low[1] ? 4'hC : 4'h3;
        end
        return m;
    endfunction : byte_lanes

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] lanes);
        logic [15:0] r;
        r = old;
        if (lanes[0]) begin
            r[7:0] = wd[7:0];
        end
        if (lanes[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // Total bits of one frame including the start bit.
    function automatic logic [3:0] frame_len(input logic [1:0] fmt, input logic two_stop);
        logic [3:0] len;
        len = (fmt == FMT_8N) ? 4'hA : 4'hB;
        if (two_stop) begin
            len = len + 4'h1;
        end
        return len;
    endfunction : frame_len

    function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d, input logic [1:0] fmt);
        logic [FRAME_W-1:0] f;
        f = '1;
        f[0] = 1'b0;
        unique case (fmt)
            FMT_8N: f[8:1] = d[7:0];
            FMT_8E: begin
                f[8:1] = d[7:0];
                f[9]   = ^d[7:0];
            end
            FMT_8O: begin
                f[8:1] = d[7:0];
                f[9]   = ~^d[7:0];
            end
            FMT_9N: f[9:1] = d;
        endcase
        return f;
    endfunction : build_frame

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        logic        on;
        logic        tick;
        logic        restart;
        logic [3:0]  last;
        logic [3:0]  mid;
        logic [1:0]  fmt;
        logic [1:0]  pins;
        logic        tx_push;
        logic        tx_pop;
        logic        rx_push;
        logic        rx_pop;
        logic        cts_ok;
        logic [8:0]  rdata;
        logic        parity_error_flag;
        logic        framing_error_flag;
        logic [3:0]  stop_pos;
        logic [10:0] rx_top;
        on       = s.mode[MODE_ON_BIT];
        tick     = (s.baud_cnt == s.baud_div);
        restart  = 1'b0;
        last     = s.mode[MODE_HIGH_SPEED] ? PHASE_LAST_HIGH : PHASE_LAST_LOW;
        mid      = s.mode[MODE_HIGH_SPEED] ? PHASE_MID_HIGH : PHASE_MID_LOW;
        fmt      = s.mode[MODE_FMT_LSB +: 2];
        pins     = s.mode[MODE_PINS_LSB +: 2];
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        cts_ok   = !(pins == PINS_FLOW || pins == PINS_BCLK) || !CLEAR_TO_SEND_N;
        rdata    = '0;
        parity_error_flag     = 1'b0;
        framing_error_flag     = 1'b0;
        stop_pos = '0;
        rx_top   = s.rxq[s.rx_rd];
        n        = s;
        n.tx_irq  = 1'b0;
        n.rx_irq  = 1'b0;
        n.err_irq = 1'b0;
        n.hresp   = 1'b0;
        n.hreadyout = 1'b1;
        n.baud_cnt = tick ? '0 : s.baud_cnt + 16'h0001;

        // Data phase of a write; the slave never stalls, so this is the cycle after the address phase.
        n.wr_pending = 1'b0;
        if (s.wr_pending) begin
            unique case (s.wr_addr)
                MODE_ADDR: n.mode = merge16(s.mode, HWDATA, s.wr_lanes);
                BAUD_ADDR: begin
                    n.baud_div = merge16(s.baud_div, HWDATA, s.wr_lanes);
                    restart    = 1'b1;
                end
                STAT_ADDR: begin
                    if (s.wr_lanes[0]) begin
                        n.rx_sel = HWDATA[STAT_RXSEL_LSB +: 2];
                        if (!HWDATA[STAT_OVERRUN_ERROR_FLAG_BIT]) begin
                            n.overrun_error_flag = 1'b0;
                        end
                    end
                    if (s.wr_lanes[1]) begin
                        n.tx_sel = HWDATA[STAT_TXSEL_LSB +: 2];
                        n.tx_en  = HWDATA[STAT_TXEN_BIT];
                        n.brk    = HWDATA[STAT_BREAK_BIT];
                        if (HWDATA[STAT_TXEN_BIT] && !s.tx_en) begin
                            n.tx_irq = 1'b1;
                            restart  = 1'b1;
                        end
                    end
                end
                TXD_ADDR: begin
                    // A byte write is enough in 8-bit formats; 9-bit data needs both low lanes.
                    if (s.wr_lanes[0] && (fmt != FMT_9N || s.wr_lanes[1]) && s.tx_cnt != CNT_FULL) begin
                        tx_push = 1'b1;
                        n.txq[s.tx_wr] = HWDATA[8:0];
                    end
                end
                default: ;
            endcase
        end

        // Address phase: read data is fetched now and stands in the data phase.
        if (HSEL && HTRANS[1] && HREADY) begin
            n.hrdata = '0;
            if (HWRITE) begin
                n.wr_pending = 1'b1;
                n.wr_addr    = HADDR[7:0];
                n.wr_lanes   = byte_lanes(HSIZE, HADDR[1:0]);
            end else begin
                unique case (HADDR[7:0])
                    MODE_ADDR: n.hrdata[15:0] = s.mode;
                    BAUD_ADDR: n.hrdata[15:0] = s.baud_div;
                    STAT_ADDR: begin
                        n.hrdata[STAT_TXSEL_LSB +: 2]  = s.tx_sel;
                        n.hrdata[STAT_BREAK_BIT]       = s.brk;
                        n.hrdata[STAT_TXEN_BIT]        = s.tx_en;
                        n.hrdata[STAT_TXFULL_BIT]      = (s.tx_cnt == CNT_FULL);
                        n.hrdata[STAT_TXIDLE_BIT]      = (s.tx_state == TX_IDLE) && (s.tx_cnt == '0);
                        n.hrdata[STAT_RXSEL_LSB +: 2]  = s.rx_sel;
                        n.hrdata[STAT_PARITY_ERROR_FLAG_BIT]        = (s.rx_cnt != '0) && rx_top[10];
                        n.hrdata[STAT_FRAMING_ERROR_FLAG_BIT]        = (s.rx_cnt != '0) && rx_top[9];
                        n.hrdata[STAT_OVERRUN_ERROR_FLAG_BIT]        = s.overrun_error_flag;
                        n.hrdata[STAT_RXAVAIL_BIT]     = (s.rx_cnt != '0);
                    end
                    RXD_ADDR: begin
                        if (s.rx_cnt != '0) begin
                            n.hrdata[8:0] = rx_top[8:0];
                            rx_pop        = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Transmitter.
        unique case (s.tx_state)
            TX_IDLE: begin
                if (on && s.tx_en && s.tx_cnt != '0 && cts_ok) begin
                    tx_pop      = 1'b1;
                    n.tx_state  = TX_SHIFT;
                    n.tx_phase  = '0;
                    n.tx_is_break = s.brk;
                    if (s.brk) begin
                        n.tx_shift = BREAK_FRAME;
                        n.tx_bits  = BREAK_BITS;
                    end else begin
                        n.tx_shift = build_frame(s.txq[s.tx_rd], fmt);
                        n.tx_bits  = frame_len(fmt, s.mode[MODE_STOP2_BIT]);
                    end
                    if (s.tx_sel == TXSEL_CHAR || s.tx_sel == RXSEL_FULL) begin
                        n.tx_irq = 1'b1;
                    end
                    if (s.tx_sel == TXSEL_EMPTY && s.tx_cnt == CNT_ONE && !tx_push) begin
                        n.tx_irq = 1'b1;
                    end
                end
            end
            TX_SHIFT: begin
                if (tick) begin
                    n.tx_phase = s.tx_phase + 4'h1;
                    if (s.tx_phase == last) begin
                        n.tx_phase = '0;
                        n.tx_shift = {1'b1, s.tx_shift[FRAME_W-1:1]};
                        n.tx_bits  = s.tx_bits - 4'h1;
                        if (s.tx_bits == 4'h1) begin
                            n.tx_state = TX_IDLE;
                            if (s.tx_is_break) begin
                                n.brk = 1'b0;
                            end
                            if (s.tx_sel == TXSEL_DONE && s.tx_cnt == '0) begin
                                n.tx_irq = 1'b1;
                            end
                        end
                    end
                end
            end
        endcase

        // Receiver.
        unique case (s.rx_state)
            RX_IDLE: begin
                if (on && tick && !SERIAL_IN_PIN) begin
                    n.rx_state = RX_BITS;
                    n.rx_phase = '0;
                    n.rx_idx   = '0;
                end
            end
            RX_BITS: begin
                if (tick) begin
                    n.rx_phase = s.rx_phase + 4'h1;
                    if (s.rx_phase == mid) begin
                        if (s.rx_idx == '0) begin
                            if (SERIAL_IN_PIN) begin
                                n.rx_state = RX_IDLE;
                            end
                        end else begin
                            n.rx_shift[s.rx_idx - 4'h1] = SERIAL_IN_PIN;
                        end
                    end
                    if (s.rx_phase == last) begin
                        n.rx_phase = '0;
                        n.rx_idx   = s.rx_idx + 4'h1;
                        if (s.rx_idx + 4'h1 == frame_len(fmt, s.mode[MODE_STOP2_BIT])) begin
                            n.rx_state = RX_IDLE;
                            rdata    = (fmt == FMT_9N) ? s.rx_shift[8:0] : {1'b0, s.rx_shift[7:0]};
                            parity_error_flag     = (fmt == FMT_8E && s.rx_shift[8] != ^s.rx_shift[7:0])
                                    || (fmt == FMT_8O && s.rx_shift[8] == ^s.rx_shift[7:0]);
                            stop_pos = (fmt == FMT_8N) ? 4'h8 : 4'h9;
                            framing_error_flag     = !s.rx_shift[stop_pos]
                                    || (s.mode[MODE_STOP2_BIT] && !s.rx_shift[stop_pos + 4'h1]);
                            if (s.mode[MODE_ADDR_DET] && fmt == FMT_9N && !rdata[8]) begin
                                // Data characters in the 9-bit format are always dropped while address detection is on, even after an address.
                                framing_error_flag = 1'b0;
                            end else if (s.rx_cnt == CNT_FULL && !rx_pop) begin
                                n.err_irq = 1'b1;
                            end else begin
                                rx_push        = 1'b1;
                                n.rxq[s.rx_wr] = {parity_error_flag, framing_error_flag, rdata};
                                n.err_irq      = parity_error_flag || framing_error_flag;
                            end
                        end
                    end
                end
            end
        endcase
        if (n.err_irq && !rx_push) begin
            n.overrun_error_flag = 1'b1;
        end

        // Queue bookkeeping; a push and a pop in one cycle leave the count unchanged.
        n.tx_wr  = s.tx_wr + AW'(tx_push);
        n.tx_rd  = s.tx_rd + AW'(tx_pop);
        n.tx_cnt = s.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
        n.rx_wr  = s.rx_wr + AW'(rx_push);
        n.rx_rd  = s.rx_rd + AW'(rx_pop);
        n.rx_cnt = s.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
        if (rx_push) begin
            unique case (s.rx_sel)
                RXSEL_LEVEL3: n.rx_irq = (n.rx_cnt == CNT_LVL3);
                RXSEL_FULL:   n.rx_irq = (n.rx_cnt == CNT_FULL);
                default:      n.rx_irq = 1'b1;
            endcase
        end

        if (restart || !on) begin
            n.baud_cnt = '0;
            n.tx_phase = '0;
            n.rx_phase = '0;
        end
        if (!on) begin
            n.tx_state = TX_IDLE;
            n.rx_state = RX_IDLE;
        end

        // Pins, registered from the next state so they change with it.
        n.serial_out = !on || n.tx_state == TX_IDLE || n.tx_shift[0];
        n.rts_n = 1'b1;
        if (on) begin
            unique case (pins)
                PINS_NONE:    n.rts_n = 1'b1;
                PINS_SIMPLEX: n.rts_n = (n.tx_state == TX_IDLE);
                PINS_FLOW:    n.rts_n = (n.rx_cnt == CNT_FULL);
                // The tick is the 16x clock at normal speed; with a divisor of zero it stays high.
                PINS_BCLK:    n.rts_n = (n.baud_cnt <= (s.baud_div >> 1));
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s            <= '0;
            s.mode       <= REG16_RESET;
            s.baud_div   <= REG16_RESET;
            s.hreadyout  <= 1'b1;
            s.serial_out <= 1'b1;
            s.rts_n      <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign HRDATA            = s.hrdata;
    assign HREADYOUT         = s.hreadyout;
    assign HRESP             = s.hresp;
    assign SERIAL_OUT_PIN    = s.serial_out;
    assign REQUEST_TO_SEND_N = s.rts_n;
    assign TX_IRQ            = s.tx_irq;
    assign RX_IRQ            = s.rx_irq;
    assign ERR_IRQ           = s.err_irq;
endmodule : async_serial_transceiver
`default_nettype wire

// ==== include/uart_pkg.sv ====
// Constants, register map and state types of the asynchronous serial transceiver.
`default_nettype none
package uart_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0]  MODE_ADDR        = 8'h00;
    localparam logic [7:0]  STAT_ADDR        = 8'h04;
    localparam logic [7:0]  TXD_ADDR         = 8'h08;
    localparam logic [7:0]  RXD_ADDR         = 8'h0C;
    localparam logic [7:0]  BAUD_ADDR        = 8'h10;
    // Fields of the mode control register.
    localparam int          MODE_ON_BIT      = 15;
    localparam int          MODE_PINS_LSB    = 8;
    localparam int          MODE_ADDR_DET    = 5;
    localparam int          MODE_HIGH_SPEED  = 3;
    localparam int          MODE_FMT_LSB     = 1;
    localparam int          MODE_STOP2_BIT   = 0;
    // Fields of the status and control register.
    localparam int          STAT_TXSEL_LSB   = 14;
    localparam int          STAT_BREAK_BIT   = 11;
    localparam int          STAT_TXEN_BIT    = 10;
    localparam int          STAT_TXFULL_BIT  = 9;
    localparam int          STAT_TXIDLE_BIT  = 8;
    localparam int          STAT_RXSEL_LSB   = 6;
    localparam int          STAT_PARITY_ERROR_FLAG_BIT    = 3;
    localparam int          STAT_FRAMING_ERROR_FLAG_BIT    = 2;
    localparam int          STAT_OVERRUN_ERROR_FLAG_BIT    = 1;
    localparam int          STAT_RXAVAIL_BIT = 0;
    // Frame formats.
    localparam logic [1:0]  FMT_8N           = 2'h0;
    localparam logic [1:0]  FMT_8E           = 2'h1;
    localparam logic [1:0]  FMT_8O           = 2'h2;
    localparam logic [1:0]  FMT_9N           = 2'h3;
    // Pin enable field codes.
    localparam logic [1:0]  PINS_NONE        = 2'h0;
    localparam logic [1:0]  PINS_SIMPLEX     = 2'h1;
    localparam logic [1:0]  PINS_FLOW        = 2'h2;
    localparam logic [1:0]  PINS_BCLK        = 2'h3;
    // Transmit and receive interrupt select codes.
    localparam logic [1:0]  TXSEL_CHAR       = 2'h0;
    localparam logic [1:0]  TXSEL_DONE       = 2'h1;
    localparam logic [1:0]  TXSEL_EMPTY      = 2'h2;
    localparam logic [1:0]  RXSEL_LEVEL3     = 2'h2;
    localparam logic [1:0]  RXSEL_FULL       = 2'h3;
    localparam int          RX_LEVEL_THREE   = 3;
    // Ticks per bit less one, and the mid-bit sample tick.
    localparam logic [3:0]  PHASE_LAST_LOW   = 4'hF;
    localparam logic [3:0]  PHASE_LAST_HIGH  = 4'h3;
    localparam logic [3:0]  PHASE_MID_LOW    = 4'h7;
    localparam logic [3:0]  PHASE_MID_HIGH   = 4'h1;
    // Frames: a break is a start bit and twelve more low bits, then one stop bit.
    localparam int          FRAME_W          = 14;
    localparam logic [13:0] BREAK_FRAME      = 14'h2000;
    localparam logic [3:0]  BREAK_BITS       = 4'hE;
    localparam logic [15:0] REG16_RESET      = 16'h0000;
    localparam logic [2:0]  HSIZE_BYTE       = 3'h0;
    localparam logic [2:0]  HSIZE_HALF       = 3'h1;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_type;
    typedef enum logic {RX_IDLE, RX_BITS}  rx_state_type;
endpackage : uart_pkg
`default_nettype wire

// ==== verification/uart_sva.sv ====
// Pin-level checker of the serial transceiver.
`timescale 1ns/10ps
`default_nettype none
module uart_sva
    import uart_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        SERIAL_OUT_PIN,
    input wire logic        TX_IRQ,
    input wire logic        RX_IRQ,
    input wire logic        ERR_IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic rd_req;
    assign rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE;
    property p_ready; HREADYOUT; endproperty
    a_ready: assert property (p_ready) else $error("slave inserted a wait state");
    property p_okay; !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("slave gave an error response");
    property p_tx_pulse; TX_IRQ |=> !TX_IRQ; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx request held too long");
    property p_rx_pulse; RX_IRQ |=> !RX_IRQ; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx request held too long");
    property p_err_pulse; ERR_IRQ |=> !ERR_IRQ; endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error request held too long");
    // The shortest legal bit is four clocks, so any change must hold three more.
    property p_bit_hold; $changed(SERIAL_OUT_PIN) |=> $stable(SERIAL_OUT_PIN)[*3]; endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("serial bit too short");
    property p_txd_zero; rd_req && HADDR[7:0] == TXD_ADDR |=> HRDATA == 32'h0000_0000; endproperty
    a_txd_zero: assert property (p_txd_zero) else $error("tx data read not zero");
    property p_unmapped; rd_req && HADDR[7:0] > BAUD_ADDR |=> HRDATA == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : uart_sva
bind async_serial_transceiver uart_sva uart_sva_i (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ), .ERR_IRQ(ERR_IRQ));
`default_nettype wire

// ==== verification/serial_partner.sv ====
// Remote serial device that sends one framed byte on request.
`timescale 1ns/10ps
`default_nettype none
module serial_partner #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] data,
    output var  logic       line
);
    logic [9:0] frame;
    initial line = 1'b1;
    always @(posedge clk) begin
        if (go) begin
            frame = {1'b1, data, 1'b0};
            for (int i = 0; i < 10; i++) begin
                line <= frame[i];
                repeat (BIT_CYCLES) @(posedge clk);
            end
        end
    end
endmodule : serial_partner
`default_nettype wire

// ==== verification/async_serial_transceiver_bench.sv ====
// Self-checking bench of the serial transceiver.
`timescale 1ns/10ps
`default_nettype none
module async_serial_transceiver_bench;
    import uart_pkg::*;
    logic        mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, go = 0, cts_n = 0;
    logic [31:0] haddr = 0, hwdata = 0, rdat;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  pdata = 0;
    wire logic [31:0] hrdata;
    wire logic   hreadyout, sin, sout, tx_irq, rx_irq, err_irq, rts_n;
    int          bad_count = 0, checks = 0, cyc = 0, tx_n = 0, rx_n = 0, err_n = 0;
    always #12.5 mclk = ~mclk;
    async_serial_transceiver async_serial_transceiver_i (.MCLK(mclk), .RST_N(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .SERIAL_IN_PIN(sin),
        .SERIAL_OUT_PIN(sout), .CLEAR_TO_SEND_N(cts_n), .REQUEST_TO_SEND_N(rts_n), .TX_IRQ(tx_irq),
        .RX_IRQ(rx_irq), .ERR_IRQ(err_irq));
    serial_partner serial_partner_i (.clk(mclk), .go(go), .data(pdata), .line(sin));
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // A hang in any wait ends here, well beyond the few thousand clocks the tests need.
    always @(posedge mclk) begin
        cyc++;
        if (tx_irq === 1'b1) tx_n++;
        if (rx_irq === 1'b1) rx_n++;
        if (err_irq === 1'b1) err_n++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h00_0000, a}; hwrite <= w; htrans <= 2'h2; hsel <= 1'b1;
        @(posedge mclk); while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        @(posedge mclk); while (hreadyout !== 1'b1) @(posedge mclk);
        rdat = hrdata;
    endtask : bus
    task cap(input logic [7:0] b, input int c);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; sout === 1'b1 && i < 400; i++) @(posedge mclk);
        repeat (c / 2) @(posedge mclk);
        for (int k = 0; k < 10; k++) begin
            chk(32'(sout), 32'(f[k]));
            repeat (c) @(posedge mclk);
        end
    endtask : cap
    task send(input logic [7:0] b);
        int n;
        n = rx_n + err_n;
        pdata <= b; go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; rx_n + err_n == n && i < 400; i++) @(posedge mclk);
        chk(32'(rx_n + err_n), 32'(n + 1));
    endtask : send
    task t_reset;
        bus(0, STAT_ADDR, 0); chk(rdat, 32'h0000_0100);
        bus(0, TXD_ADDR, 0); chk(rdat, 32'h0000_0000);
        bus(0, 8'h14, 0); chk(rdat, 32'h0000_0000);
        $display("reset test done");
    endtask : t_reset
    task t_tx;
        int n;
        bus(1, BAUD_ADDR, 0); bus(1, MODE_ADDR, 32'h0000_8000);
        n = tx_n;
        bus(1, STAT_ADDR, 32'h0000_0400); repeat (4) @(posedge mclk);
        chk(32'(tx_n), 32'(n + 1));
        bus(1, TXD_ADDR, 32'h0000_00A5); cap(8'hA5, 16);
        bus(1, MODE_ADDR, 32'h0000_8008); bus(1, BAUD_ADDR, 1);
        bus(1, TXD_ADDR, 32'h0000_003C); cap(8'h3C, 8);
        bus(1, STAT_ADDR, 32'h0000_0C00); bus(1, TXD_ADDR, 32'h0000_00FF); bus(1, TXD_ADDR, 32'h0000_0055);
        for (int i = 0; sout === 1'b1 && i < 400; i++) @(posedge mclk);
        repeat (4 + 12 * 8) @(posedge mclk); chk(32'(sout), 0);
        repeat (8) @(posedge mclk); chk(32'(sout), 1);
        cap(8'h55, 8); bus(0, STAT_ADDR, 0); chk(rdat & 32'h0000_0800, 0);
        $display("transmit test done");
    endtask : t_tx
    task t_rx;
        bus(1, MODE_ADDR, 32'h0000_8000); bus(1, BAUD_ADDR, 0);
        send(8'h3C); bus(0, RXD_ADDR, 0); chk(rdat, 32'h0000_003C);
        chk(32'(rx_n), 1);
        for (int i = 0; i < 5; i++) send(8'h10 + 8'(i));
        chk(32'(err_n), 1);
        chk(32'(rx_n), 5);
        repeat (50) @(posedge mclk);
        bus(0, STAT_ADDR, 0); chk(rdat & 32'h0000_0003, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            bus(0, RXD_ADDR, 0); chk(rdat, 32'h0000_0010 + i);
        end
        bus(1, STAT_ADDR, 32'h0000_0400); bus(0, STAT_ADDR, 0); chk(rdat & 32'h0000_0003, 0);
        $display("receive test done");
    endtask : t_rx
    task t_pins;
        bus(1, MODE_ADDR, 32'h0000_8100); bus(1, TXD_ADDR, 32'h0000_0081);
        repeat (8) @(posedge mclk); chk(32'(rts_n), 0);
        repeat (200) @(posedge mclk); chk(32'(rts_n), 1);
        cts_n <= 1'b1; bus(1, MODE_ADDR, 32'h0000_8200); bus(1, TXD_ADDR, 32'h0000_0042);
        repeat (40) @(posedge mclk); chk(32'(sout), 1);
        chk(32'(rts_n), 0);
        cts_n <= 1'b0; cap(8'h42, 16);
        bus(1, BAUD_ADDR, 1); bus(1, MODE_ADDR, 32'h0000_8300);
        repeat (2) @(posedge mclk); rdat = 32'(rts_n);
        @(posedge mclk); chk(rdat ^ 32'(rts_n), 1);
        $display("pin test done");
    endtask : t_pins
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_tx();
        t_rx();
        t_pins();
        tally_and_finish();
    end
endmodule : async_serial_transceiver_bench
`default_nettype wire
